// >>> hw/tisr_params.svh
// offsets, field positions, reset values and timing counts of the status register group
// Notes on behaviour
// - temperature reading is 8-bit two's complement, zero meaning 23 degrees Celsius.
// - each status flag sets when its interrupt engine fires its trigger.
// - latch-mode setting picks permanent, temporary or no latching for every flag.
// - motion flags: flat bit 7, orientation 6, single tap 5, double tap 4.
// - motion flags: no-motion bit 3, slope 2, high-g 1, low-g 0.
// - data-ready bit 7, watermark 6, FIFO full 5, bits 4 to 0 reserved.
// - axis-source bit 7 holds last tap sign, 0 positive, 1 negative.
// - axis-source bits 6, 5, 4 mark z, y, x as tap trigger axis.
// - axis-source bit 3 holds slope trigger sign, 0 positive, 1 negative.
// - axis-source bits 2, 1, 0 mark z, y, x as slope trigger axis.
`ifndef TISR_PARAMS_SVH
`define TISR_PARAMS_SVH

// register offsets
`define TISR_OFS_HEAT        8'h08
`define TISR_OFS_MOTION      8'h09
`define TISR_OFS_DATA_FIFO   8'h0A
`define TISR_OFS_AXIS        8'h0B

// motion_event_flags field positions
`define TISR_BIT_FLAT        7
`define TISR_BIT_ORIENT      6
`define TISR_BIT_S_TAP       5
`define TISR_BIT_D_TAP       4
`define TISR_BIT_NO_MOT      3
`define TISR_BIT_SLOPE       2
`define TISR_BIT_HIGH_G      1
`define TISR_BIT_LOW_G       0

// data_fifo_event_flags field positions
`define TISR_BIT_DATA_RDY    7
`define TISR_BIT_QUEUE_THR   6
`define TISR_BIT_FIFO_FULL   5

// event_axis_source field positions
`define TISR_BIT_TAP_SIGN    7
`define TISR_BIT_TAP_AXIS    4
`define TISR_BIT_SLOPE_SIGN  3
`define TISR_BIT_SLOPE_AXIS  0

// latch-mode codes that are not temporary
`define TISR_LATCH_NONE      4'h0
`define TISR_LATCH_PERM_A    4'h7
`define TISR_LATCH_PERM_B    4'hF

// reset and unmapped read values
`define TISR_RST_BYTE        8'h00
`define TISR_UNMAPPED_BYTE   8'h00

// temporary latch hold time and its cycle count at 125 MHz
`define TISR_CLK_PERIOD_NS   8
`define TISR_TEMP_HOLD_NS    2000
`define TISR_TEMP_HOLD_CYC   ((`TISR_TEMP_HOLD_NS + `TISR_CLK_PERIOD_NS - 1) / `TISR_CLK_PERIOD_NS)

`endif

// >>> hw/tisr_pkg.sv
// types shared by the status register group
package tisr_pkg;
  typedef enum logic [1:0] {
    TISR_LM_NONE,
    TISR_LM_TEMP,
    TISR_LM_PERM
  } tisr_latch_t;
endpackage

// >>> hw/tisr_flag_cell.sv
// one interrupt status flag with its latching behaviour
`include "tisr_params.svh"
module tisr_flag_cell
  import tisr_pkg::*;
#(
  parameter int HOLD_W = 8,
  parameter int HOLD   = 250
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // control
  input  wire tisr_latch_t mode,
  input  wire logic        clr,
  // engine trigger
  input  wire logic        trig,
  // status
  output logic             flag
);

  // refuse a hold count that the counter cannot carry
  if (HOLD_W < 1 || HOLD_W > 30 || HOLD < 1 || HOLD >= (1 << HOLD_W)) begin : g_bad_hold
    $error("tisr_flag_cell: HOLD does not fit HOLD_W");
  end

  logic              flag_q;
  logic              flag_d;
  logic [HOLD_W-1:0] cnt_q;
  logic [HOLD_W-1:0] cnt_d;

  // next flag and hold count; a trigger always beats a clear
  always_comb begin
    flag_d = flag_q;
    cnt_d  = cnt_q;
    case (mode)
      TISR_LM_NONE: begin
        flag_d = trig;
        cnt_d  = '0;
      end
      TISR_LM_PERM: begin
        flag_d = trig | (flag_q & ~clr);
        cnt_d  = '0;
      end
      TISR_LM_TEMP: begin
        if (trig) begin
          flag_d = 1'b1;
          cnt_d  = HOLD_W'(HOLD);
        end else begin
          flag_d = flag_q & ~clr & (cnt_q > HOLD_W'(1));   // no count left: drop
          cnt_d  = (clr || cnt_q == '0) ? '0 : cnt_q - HOLD_W'(1);
        end
      end
      default: begin
        flag_d = trig;
        cnt_d  = '0;
      end
    endcase
  end

  // flag state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_q <= 1'b0;
      cnt_q  <= '0;
    end else begin
      flag_q <= flag_d;
      cnt_q  <= cnt_d;
    end
  end

  assign flag = flag_q;

endmodule // tisr_flag_cell

// >>> hw/tisr_status_regs.sv
// temperature reading and interrupt status registers with read port
`include "tisr_params.svh"
module tisr_status_regs
  import tisr_pkg::*;
#(
  parameter int HOLD_CYC = `TISR_TEMP_HOLD_CYC,
  parameter int HOLD_W   = 16
) (
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  // register read port from the serial interface
  input  wire logic       RD_EN,
  input  wire logic [7:0] RD_ADDR,
  output logic      [7:0] RD_DATA,
  output logic            RD_VALID,
  // latch control
  input  wire logic [3:0] LATCH_MODE,
  input  wire logic       LATCH_CLR,
  // temperature sensor
  input  wire logic [7:0] CHIP_HEAT_IN,
  // motion engine triggers
  input  wire logic       FLAT_TRIG,
  input  wire logic       ORIENT_TRIG,
  input  wire logic       S_TAP_TRIG,
  input  wire logic       D_TAP_TRIG,
  input  wire logic       NO_MOT_TRIG,
  input  wire logic       SLOPE_TRIG,
  input  wire logic       HIGH_G_TRIG,
  input  wire logic       LOW_G_TRIG,
  // data and FIFO engine triggers
  input  wire logic       DATA_RDY_TRIG,
  input  wire logic       QUEUE_THRESHOLD_TRIG,
  input  wire logic       FIFO_FULL_TRIG,
  // trigger axis and sign reported by the tap and slope engines
  input  wire logic       TAP_SIGN,
  input  wire logic [2:0] TAP_AXIS,
  input  wire logic       SLOPE_SIGN,
  input  wire logic [2:0] SLOPE_AXIS
);

  // refuse a hold time that the flag counters cannot carry
  if (HOLD_W < 1 || HOLD_W > 30 ||
      HOLD_CYC < 1 || HOLD_CYC >= (1 << HOLD_W)) begin : g_bad_hold
    $error("tisr_status_regs: HOLD_CYC does not fit HOLD_W");
  end

  localparam int NFLAG = 11;

  tisr_latch_t      mode;
  logic [NFLAG-1:0] trig_vec;
  logic [NFLAG-1:0] flag_vec;
  logic [7:0]       motion_byte;
  logic [7:0]       data_fifo_byte;
  logic [7:0]       heat_q;
  logic [7:0]       heat_d;
  logic [7:0]       axis_q;
  logic [7:0]       axis_d;
  logic [7:0]       rd_data_q;
  logic [7:0]       rd_data_d;
  logic             rd_valid_q;
  logic             rd_valid_d;

  // decode the 4-bit latch setting into a latching style
  always_comb begin
    case (LATCH_MODE)
      `TISR_LATCH_NONE:   mode = TISR_LM_NONE;
      `TISR_LATCH_PERM_A: mode = TISR_LM_PERM;
      `TISR_LATCH_PERM_B: mode = TISR_LM_PERM;
      default:            mode = TISR_LM_TEMP;
    endcase
  end

  // trigger vector: motion flags in low eight, data/FIFO flags above
  assign trig_vec = {FIFO_FULL_TRIG, QUEUE_THRESHOLD_TRIG, DATA_RDY_TRIG,
                     FLAT_TRIG, ORIENT_TRIG, S_TAP_TRIG, D_TAP_TRIG,
                     NO_MOT_TRIG, SLOPE_TRIG, HIGH_G_TRIG, LOW_G_TRIG};

  // one latching flag per interrupt engine
  genvar gi;
  generate
    for (gi = 0; gi < NFLAG; gi++) begin : g_flag
      tisr_flag_cell #(
        .HOLD_W (HOLD_W),
        .HOLD   (HOLD_CYC)
      ) u_cell (
        .clk  (CLK),
        .rst  (SYS_RST),
        .mode (mode),
        .clr  (LATCH_CLR),
        .trig (trig_vec[gi]),
        .flag (flag_vec[gi])
      );
    end
  endgenerate

  // motion flags placed at their register bit positions
  always_comb begin
    motion_byte                   = 8'h00;
    motion_byte[`TISR_BIT_FLAT]   = flag_vec[7];
    motion_byte[`TISR_BIT_ORIENT] = flag_vec[6];
    motion_byte[`TISR_BIT_S_TAP]  = flag_vec[5];
    motion_byte[`TISR_BIT_D_TAP]  = flag_vec[4];
    motion_byte[`TISR_BIT_NO_MOT] = flag_vec[3];
    motion_byte[`TISR_BIT_SLOPE]  = flag_vec[2];
    motion_byte[`TISR_BIT_HIGH_G] = flag_vec[1];
    motion_byte[`TISR_BIT_LOW_G]  = flag_vec[0];
  end

  // data/FIFO flags; reserved low bits read as zero
  always_comb begin
    data_fifo_byte                      = 8'h00;
    data_fifo_byte[`TISR_BIT_DATA_RDY]  = flag_vec[8];
    data_fifo_byte[`TISR_BIT_QUEUE_THR] = flag_vec[9];
    data_fifo_byte[`TISR_BIT_FIFO_FULL] = flag_vec[10];
  end

  // temperature sample and axis capture on tap and slope events
  always_comb begin
    heat_d = CHIP_HEAT_IN;
    axis_d = axis_q;
    if (S_TAP_TRIG || D_TAP_TRIG) begin
      axis_d[`TISR_BIT_TAP_SIGN]                      = TAP_SIGN;
      axis_d[`TISR_BIT_TAP_AXIS+2:`TISR_BIT_TAP_AXIS] = TAP_AXIS;
    end
    if (SLOPE_TRIG) begin
      axis_d[`TISR_BIT_SLOPE_SIGN]                        = SLOPE_SIGN;
      axis_d[`TISR_BIT_SLOPE_AXIS+2:`TISR_BIT_SLOPE_AXIS] = SLOPE_AXIS;
    end
  end

  // read decode; unmapped addresses answer zero
  always_comb begin
    rd_valid_d = RD_EN;
    rd_data_d  = rd_data_q;
    if (RD_EN) begin
      case (RD_ADDR)
        `TISR_OFS_HEAT:      rd_data_d = heat_q;
        `TISR_OFS_MOTION:    rd_data_d = motion_byte;
        `TISR_OFS_DATA_FIFO: rd_data_d = data_fifo_byte;
        `TISR_OFS_AXIS:      rd_data_d = axis_q;
        default:             rd_data_d = `TISR_UNMAPPED_BYTE;
      endcase
    end
  end

  // register stage
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      heat_q     <= `TISR_RST_BYTE;
      axis_q     <= `TISR_RST_BYTE;
      rd_data_q  <= `TISR_RST_BYTE;
      rd_valid_q <= 1'b0;
    end else begin
      heat_q     <= heat_d;
      axis_q     <= axis_d;
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign RD_DATA  = rd_data_q;
  assign RD_VALID = rd_valid_q;

endmodule // tisr_status_regs

// >>> testbench/tisr_status_regs_assertions.sv
// port checks for the status register group
module tisr_chk #(
  parameter int HOLD_CYC = 4
) (
  // watched ports
  input wire logic       CLK, SYS_RST, RD_EN, RD_VALID, TAP_SIGN, SLOPE_SIGN,
  input wire logic [7:0] RD_ADDR, RD_DATA, CHIP_HEAT_IN,
  input wire logic [3:0] LATCH_MODE,
  input wire logic [2:0] TAP_AXIS, SLOPE_AXIS,
  input wire logic       FLAT_TRIG, ORIENT_TRIG, S_TAP_TRIG, D_TAP_TRIG, NO_MOT_TRIG,
  input wire logic       SLOPE_TRIG, HIGH_G_TRIG, LOW_G_TRIG,
  input wire logic       DATA_RDY_TRIG, QUEUE_THRESHOLD_TRIG, FIFO_FULL_TRIG
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // triggers in register bit order
  wire logic [7:0] mot = {FLAT_TRIG, ORIENT_TRIG, S_TAP_TRIG, D_TAP_TRIG,
                          NO_MOT_TRIG, SLOPE_TRIG, HIGH_G_TRIG, LOW_G_TRIG};
  wire logic [2:0] dfv = {DATA_RDY_TRIG, QUEUE_THRESHOLD_TRIG, FIFO_FULL_TRIG};
  // a tap or slope event followed by a read of the axis source
  sequence s_tap;
    (S_TAP_TRIG || D_TAP_TRIG) ##1 (RD_EN && RD_ADDR == 8'h0B);
  endsequence
  sequence s_slope;
    SLOPE_TRIG ##1 (RD_EN && RD_ADDR == 8'h0B);
  endsequence
  // a low-g trigger followed by a read of the motion flags
  sequence s_low_g;
    LOW_G_TRIG ##1 (RD_EN && RD_ADDR == 8'h09);
  endsequence
  AST_SET: assert property (s_low_g |=> RD_DATA[0])
    else $error("low-g flag not set by its trigger");
  AST_VALID: assert property (RD_VALID == $past(RD_EN) || $past(SYS_RST))
    else $error("read valid not one cycle after request");
  AST_RST: assert property (disable iff (1'b0) SYS_RST |=> !RD_VALID && RD_DATA == 8'h00)
    else $error("read port not cleared by reset");
  AST_HEAT: assert property (RD_EN && RD_ADDR == 8'h08 && !$past(SYS_RST)
    |=> RD_DATA == $past(CHIP_HEAT_IN, 2)) else $error("heat reading wrong");
  AST_MOT: assert property (RD_EN && RD_ADDR == 8'h09 && $past(LATCH_MODE) == 4'h0
    && !$past(SYS_RST) |=> RD_DATA == $past(mot, 2)) else $error("motion flags wrong");
  AST_DF: assert property (RD_EN && RD_ADDR == 8'h0A && $past(LATCH_MODE) == 4'h0
    && !$past(SYS_RST) |=> RD_DATA == {$past(dfv, 2), 5'h00}) else $error("fifo flags wrong");
  AST_MAP: assert property (RD_EN && (RD_ADDR < 8'h08 || RD_ADDR > 8'h0B)
    |=> RD_DATA == 8'h00) else $error("unmapped read not zero");
  AST_TAP: assert property (s_tap |=> RD_DATA[7:4] == $past({TAP_SIGN, TAP_AXIS}, 2))
    else $error("tap source wrong");
  AST_SLOPE: assert property (s_slope |=> RD_DATA[3:0] == $past({SLOPE_SIGN, SLOPE_AXIS}, 2))
    else $error("slope source wrong");
endmodule // tisr_chk

bind tisr_status_regs tisr_chk #(.HOLD_CYC(HOLD_CYC)) u_chk (.*);

// >>> testbench/tisr_host.sv
// host model issuing single-byte register reads
module tisr_host (
  // clock
  input wire logic       clk,
  // read port
  output logic           rd_en,
  output logic     [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic       rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle port; only reads are made, so reserved bits are never supplied
  initial begin
    rd_en = 1'b0;
    rd_addr = 8'h00;
  end
  // flags are trusted only for engines the bench drives, i.e. enabled
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    rd_addr <= ~a;
    @(posedge clk);
    d = rd_data;
    v = rd_valid;
  endtask
endmodule // tisr_host

// >>> testbench/test_tisr_status_regs.sv
// self-checking bench for the status register group
module test_tisr_status_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 4;
  logic       clk, rst, rd_en, rd_valid, clr, tsg, ssg, vld;
  logic [7:0] rd_addr, rd_data, heat, mot, got, a;
  logic [3:0] lmode, tsrc, ssrc;
  logic [2:0] dfv, tax, sax;
  int         bad_count = 0;
  int         checks_done = 0;
  int         cyc = 0;
  tisr_status_regs #(.HOLD_CYC(HOLD)) DUT (
    .CLK(clk), .SYS_RST(rst), .RD_EN(rd_en), .RD_ADDR(rd_addr), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .LATCH_MODE(lmode), .LATCH_CLR(clr), .CHIP_HEAT_IN(heat),
    .FLAT_TRIG(mot[7]), .ORIENT_TRIG(mot[6]), .S_TAP_TRIG(mot[5]), .D_TAP_TRIG(mot[4]),
    .NO_MOT_TRIG(mot[3]), .SLOPE_TRIG(mot[2]), .HIGH_G_TRIG(mot[1]), .LOW_G_TRIG(mot[0]),
    .DATA_RDY_TRIG(dfv[2]), .QUEUE_THRESHOLD_TRIG(dfv[1]), .FIFO_FULL_TRIG(dfv[0]),
    .TAP_SIGN(tsg), .TAP_AXIS(tax), .SLOPE_SIGN(ssg), .SLOPE_AXIS(sax));
  tisr_host HOST (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid));
  // expected byte for a held, unlatched stimulus
  function automatic logic [7:0] exp_b(input logic [7:0] x);
    case (x)
      8'h08: return heat;
      8'h09: return mot;
      8'h0A: return {dfv, 5'h00};
      8'h0B: return {tsrc, ssrc};
      default: return 8'h00;
    endcase
  endfunction
  // read one byte and compare it
  task automatic rx(input logic [7:0] x, input logic [7:0] e);
    HOST.rd(x, got, vld);
    checks_done++;
    if (vld !== 1'b1 || got !== e) begin
      bad_count++;
      $display("CHECK FAILED at %0t: addr 0x%0h read 0x%0h want 0x%0h", $time, x, got, e);
    end
  endtask
  task automatic stop_test();
    if (bad_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    {rst, lmode, clr, heat, mot, dfv} = {1'b1, 4'h0, 1'b0, 8'h00, 8'h00, 3'h0};
    {tsg, tax, ssg, sax, tsrc, ssrc} = 16'h0000;
    void'($urandom(32'h80589234));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 8; i <= 12; i++) rx(8'(i), exp_b(8'(i)));
    // random triggers with all-ones and most negative heat first
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      heat <= (i == 0) ? 8'h80 : 8'($urandom);
      mot <= (i == 0) ? 8'hFF : 8'($urandom);
      dfv <= (i == 0) ? 3'h7 : 3'($urandom);
      {tsg, tax, ssg, sax} <= 8'($urandom);
      @(posedge clk);
      if (mot[5] || mot[4]) tsrc = {tsg, tax};
      if (mot[2]) ssrc = {ssg, sax};
      a = 8'($urandom_range(7, 12));
      rx(a, exp_b(a));
    end
    @(posedge clk);
    mot <= 8'h00;
    dfv <= 3'h0;
    // every latch code: set, wait past the hold time, clear
    for (int m = 0; m < 16; m++) begin
      @(posedge clk);
      lmode <= 4'(m);
      mot <= 8'h01;
      rx(8'h09, 8'h01);
      mot <= 8'h00;
      // last cycle of a temporary hold: only the unlatched style has let go
      repeat (HOLD - 2) @(posedge clk);
      rx(8'h09, {7'h00, (m != 0)});
      repeat (2 * HOLD) @(posedge clk);
      rx(8'h09, {7'h00, (m == 7 || m == 15)});
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      rx(8'h09, 8'h00);
    end
    // permanent latch: a trigger in the clearing cycle wins, then the flag stays
    @(posedge clk);
    clr <= 1'b1;
    mot <= 8'h01;
    rx(8'h09, 8'h01);
    clr <= 1'b0;
    mot <= 8'h00;
    rx(8'h09, 8'h01);
    rx(8'h0B, {tsrc, ssrc});
    // reset in mid-run clears the axis source
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rx(8'h0B, 8'h00);
    rx(8'h09, 8'h00);
    stop_test();
  end
endmodule // test_tisr_status_regs
